/* File: verilog/rf_iq_pkg.sv */
// Shared constants and types for the baseband I/Q port
package rf_iq_pkg;
   localparam int SAMPLE_W   = 12;
   localparam int ADDR_W     = 7;
   localparam int BYTE_W     = 8;
   localparam int STORE_D    = 16;
   localparam int PTR_W      = 4;
   localparam int CNT_W      = 5;
   localparam int BIT_W      = 8;
   localparam int HALF_W     = 4;
   localparam int LAT_W      = 4;

   localparam int CLOCK_NS       = 10;
   localparam int SPI_HALF_NS    = 50;
   localparam int SPI_HALF_CYC   = (SPI_HALF_NS + CLOCK_NS - 1) / CLOCK_NS;
   localparam int FB_SKEW_NS     = 30;
   localparam int FB_SKEW_CYC    = FB_SKEW_NS / CLOCK_NS;
   localparam int MCLK_NOM_MHZ   = 90;

   localparam logic [HALF_W-1:0] TX_START_HALVES = 4'h4;
   localparam logic [HALF_W-1:0] RX_START_HALVES = 4'h4;
   localparam logic [LAT_W-1:0]  RX_LATENCY      = 4'h8;
   localparam logic [HALF_W-1:0] SPI_HALF_LAST   = HALF_W'(SPI_HALF_CYC - 1);

   localparam logic [BIT_W-1:0]  HEADER_BITS = 8'h08;
   localparam logic [BIT_W-1:0]  TURN_BITS   = 8'h01;
   localparam logic [BIT_W-1:0]  BIT_ZERO    = 8'h00;
   localparam logic [CNT_W-1:0]  STORE_FULL  = 5'h10;
   localparam logic [2:0]        BIT_IN_BYTE_LAST = 3'h7;
   localparam logic              CMD_READ    = 1'b1;

   typedef enum logic [1:0] {
      CTL_IDLE    = 2'b00,
      CTL_COLLECT = 2'b01,
      CTL_SHIFT   = 2'b11,
      CTL_FINISH  = 2'b10
   } ctlState_t;
endpackage

/* File: verilog/ctl_byte_store.sv */
// Byte store for burst control writes, registered read
`timescale 1ns/10ps
`default_nettype none
module ctl_byte_store
   import rf_iq_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              wrEn,
   input  wire logic [PTR_W-1:0]  wrAddr,
   input  wire logic [BYTE_W-1:0] wrData,
   input  wire logic [PTR_W-1:0]  rdAddr,
   output logic      [BYTE_W-1:0] rdData
);
   typedef struct packed {
      logic [STORE_D-1:0][BYTE_W-1:0] mem;
      logic [BYTE_W-1:0]              rd;
   } store_t;

   store_t st_r;
   store_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (wrEn) begin
         st_nxt.mem[wrAddr] = wrData;
      end
      st_nxt.rd = st_r.mem[rdAddr];
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdData = st_r.rd;
endmodule
`default_nettype wire

/* File: verilog/rf_baseband_iq_port.sv */
// Baseband side I/Q sample port with optional serial control master
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Ready low during control transaction, else high
// - Read byte updated with valid, then held
// - Select active low, serial clock driven out
// - Four-wire sends on mosi, receives miso
// - Three-wire uses one shared data line
// - Transmit data centred in feedback clock phases
// - Transmit burst starts after 2 cycles
// - Receive data captured on both clock edges
// - Receive burst starts after 2 cycles
// - Transmit samples ignored while enable low
// - Receive samples delivered 8 cycles after enable
// - Frame carries command, address, then data
// - Device drives write data, radio read data
// - Seven address bits, eight data bits, MSB first
// - Three-wire releases line after last address
// - Single read answered with byte and valid
// - Burst read returns each byte with valid
// - Control port optional, four or three wire
// - Clocks derived from 90 MHz master clock
// - Sample bus twelve bits, I/Q multiplexed
// - Direction high transmit, low receive
// - Framing pulse at burst start and end
// - Single asynchronous active-low reset
module rf_baseband_iq_port
   import rf_iq_pkg::*;
#(
   parameter bit CTL_PRESENT   = 1'b1,
   parameter bit CTL_FOUR_WIRE = 1'b1
)(
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire logic                masterClock,
   output logic                     feedbackClock,
   output logic                     sysClock,
   output logic                     burstFrame,
   output logic                     burstDir,
   input  wire logic [SAMPLE_W-1:0] sampleBusIn,
   output logic      [SAMPLE_W-1:0] sampleBusOut,
   output logic                     sampleBusOe,
   input  wire logic                txEn,
   input  wire logic [SAMPLE_W-1:0] txDataI,
   input  wire logic [SAMPLE_W-1:0] txDataQ,
   input  wire logic                rxEn,
   output logic      [SAMPLE_W-1:0] rxDataI,
   output logic      [SAMPLE_W-1:0] rxDataQ,
   output logic                     ctlReady,
   input  wire logic                ctlWriteStrobe,
   input  wire logic [BYTE_W-1:0]   ctlWriteByte,
   input  wire logic                ctlReadStrobe,
   output logic      [BYTE_W-1:0]   ctlReadByte,
   output logic                     ctlReadValid,
   input  wire logic [ADDR_W-1:0]   ctlRegAddress,
   output logic                     ctlSerialClock,
   output logic                     ctlSelectN,
   output logic                     mosi,
   input  wire logic                miso,
   input  wire logic                cpdioIn,
   output logic                     cpdioOut,
   output logic                     cpdioOe
);
   typedef struct packed {
      logic                   mS1, mS2, mPrev;
      logic [FB_SKEW_CYC-1:0] skew;
      logic                   sysClk;
      logic [SAMPLE_W-1:0]    diqS1, diqS2;
      logic                   misoS1, misoS2, dioS1, dioS2;
      logic                   txEnPrev, rxEnPrev, txAct, rxAct;
      logic [HALF_W-1:0]      halves;
      logic [SAMPLE_W-1:0]    txI, txQ, busOut, capI, rxI, rxQ;
      logic                   busOe, frame, dir;
      logic [LAT_W-1:0]       rxLat;
      ctlState_t              ctl;
      logic                   isRead, ready, sck, csN, mosiO, dioO, dioOe;
      logic [ADDR_W-1:0]      addr;
      logic [CNT_W-1:0]       bytes;
      logic [HALF_W-1:0]      tick;
      logic [BIT_W-1:0]       bitCnt;
      logic [BYTE_W-1:0]      shift, rdByte;
      logic                   rdValid;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   logic              memWe;
   logic [PTR_W-1:0]  memWa;
   logic [PTR_W-1:0]  memRa;
   logic [BYTE_W-1:0] memRd;
   logic              mRise, mFall, inBit;
   logic [BIT_W-1:0]  dataStart, frameEnd, dataIdx;

   ctl_byte_store store (
      .clock  (clock),
      .rst_n  (rst_n),
      .wrEn   (memWe),
      .wrAddr (memWa),
      .wrData (ctlWriteByte),
      .rdAddr (memRa),
      .rdData (memRd)
   );

   // Serial bit for a frame position: command, address, data
   function automatic logic frameBit(input logic [BIT_W-1:0] idx, input logic rd,
                                     input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d,
                                     input logic [BIT_W-1:0] ds);
      logic [BIT_W-1:0] off;
      off = idx - ds;
      if (idx == BIT_ZERO) begin
         frameBit = rd;
      end else if (idx < HEADER_BITS) begin
         frameBit = a[3'(HEADER_BITS - 8'h01 - idx)];
      end else if (idx >= ds) begin
         frameBit = d[3'(BIT_IN_BYTE_LAST - off[2:0])];
      end else begin
         frameBit = 1'b0;
      end
   endfunction

   assign mRise     = st_r.mS2 & ~st_r.mPrev;
   assign mFall     = ~st_r.mS2 & st_r.mPrev;
   assign dataStart = CTL_FOUR_WIRE ? HEADER_BITS : HEADER_BITS + TURN_BITS;
   assign frameEnd  = dataStart + {st_r.bytes, 3'h0} - 8'h01;
   assign dataIdx   = st_r.bitCnt - dataStart;
   assign memRa     = dataIdx[PTR_W+2:3];
   assign inBit     = CTL_FOUR_WIRE ? st_r.misoS2 : st_r.dioS2;

   always_comb begin
      st_nxt = st_r;
      memWe  = 1'b0;
      memWa  = st_r.bytes[PTR_W-1:0];
      // Pin synchronisers and derived clocks
      st_nxt.mS1    = masterClock;
      st_nxt.mS2    = st_r.mS1;
      st_nxt.mPrev  = st_r.mS2;
      st_nxt.sysClk = st_r.mS2;
      st_nxt.skew   = {st_r.skew[FB_SKEW_CYC-2:0], st_r.mS2};
      st_nxt.diqS1  = sampleBusIn;
      st_nxt.diqS2  = st_r.diqS1;
      st_nxt.misoS1 = miso;
      st_nxt.misoS2 = st_r.misoS1;
      st_nxt.dioS1  = cpdioIn;
      st_nxt.dioS2  = st_r.dioS1;
      st_nxt.txEnPrev = txEn;
      st_nxt.rxEnPrev = rxEn;
      st_nxt.frame    = 1'b0;
      st_nxt.rdValid  = 1'b0;

      // Data path bursts
      if (!st_r.txAct && !st_r.rxAct) begin
         if (txEn && !st_r.txEnPrev) begin
            st_nxt.txAct  = 1'b1;
            st_nxt.dir    = 1'b1;
            st_nxt.frame  = 1'b1;
            st_nxt.halves = '0;
         end else if (rxEn && !st_r.rxEnPrev) begin
            st_nxt.rxAct  = 1'b1;
            st_nxt.dir    = 1'b0;
            st_nxt.frame  = 1'b1;
            st_nxt.halves = '0;
            st_nxt.rxLat  = '0;
         end
      end else if (st_r.txAct) begin
         if (!txEn) begin
            st_nxt.txAct = 1'b0;
            st_nxt.frame = 1'b1;
            st_nxt.busOe = 1'b0;
         end else if (mRise || mFall) begin
            if (mRise) begin
               st_nxt.txI = txDataI;
               st_nxt.txQ = txDataQ;
            end
            if (st_r.halves < TX_START_HALVES) begin
               st_nxt.halves = st_r.halves + 4'h1;
            end else begin
               st_nxt.busOe  = 1'b1;
               st_nxt.busOut = mRise ? st_r.txI : st_r.txQ;
            end
         end
      end else begin
         if (!rxEn) begin
            st_nxt.rxAct = 1'b0;
            st_nxt.frame = 1'b1;
         end else begin
            if (mRise && st_r.rxLat < RX_LATENCY) begin
               st_nxt.rxLat = st_r.rxLat + 4'h1;
            end
            if (mRise || mFall) begin
               if (st_r.halves < RX_START_HALVES) begin
                  st_nxt.halves = st_r.halves + 4'h1;
               end else if (mRise) begin
                  st_nxt.capI = st_r.diqS2;
               end else if (st_r.rxLat == RX_LATENCY) begin
                  st_nxt.rxI = st_r.capI;
                  st_nxt.rxQ = st_r.diqS2;
               end
            end
         end
      end

      // Serial control master
      case (st_r.ctl)
         CTL_IDLE: begin
            st_nxt.csN = 1'b1;
            st_nxt.sck = 1'b0;
            if (CTL_PRESENT && st_r.ready && (ctlWriteStrobe || ctlReadStrobe)) begin
               st_nxt.ctl    = CTL_COLLECT;
               st_nxt.ready  = 1'b0;
               st_nxt.addr   = ctlRegAddress;
               st_nxt.isRead = ctlReadStrobe ? CMD_READ : ~CMD_READ;
               st_nxt.bytes  = 5'h01;
               memWe         = ~ctlReadStrobe;
               memWa         = '0;
            end
         end
         CTL_COLLECT: begin
            if ((st_r.isRead ? ctlReadStrobe : ctlWriteStrobe) && st_r.bytes < STORE_FULL) begin
               st_nxt.bytes = st_r.bytes + 5'h01;
               memWe        = ~st_r.isRead;
            end else begin
               st_nxt.ctl    = CTL_SHIFT;
               st_nxt.csN    = 1'b0;
               st_nxt.bitCnt = BIT_ZERO;
               st_nxt.tick   = '0;
            end
         end
         CTL_SHIFT: begin
            st_nxt.mosiO = frameBit(st_r.bitCnt, st_r.isRead, st_r.addr, memRd, dataStart);
            st_nxt.dioO  = st_nxt.mosiO;
            st_nxt.dioOe = !CTL_FOUR_WIRE && ((st_r.bitCnt < HEADER_BITS) ||
                           (!st_r.isRead && st_r.bitCnt >= dataStart));
            st_nxt.tick  = st_r.tick + 4'h1;
            if (st_r.tick == SPI_HALF_LAST) begin
               st_nxt.tick = '0;
               st_nxt.sck  = ~st_r.sck;
               if (!st_r.sck) begin
                  if (st_r.isRead && st_r.bitCnt >= dataStart) begin
                     st_nxt.shift = {st_r.shift[BYTE_W-2:0], inBit};
                     if (dataIdx[2:0] == BIT_IN_BYTE_LAST) begin
                        st_nxt.rdByte  = {st_r.shift[BYTE_W-2:0], inBit};
                        st_nxt.rdValid = 1'b1;
                     end
                  end
               end else if (st_r.bitCnt == frameEnd) begin
                  st_nxt.ctl   = CTL_FINISH;
                  st_nxt.csN   = 1'b1;
                  st_nxt.dioOe = 1'b0;
               end else begin
                  st_nxt.bitCnt = st_r.bitCnt + 8'h01;
               end
            end
         end
         CTL_FINISH: begin
            st_nxt.tick = st_r.tick + 4'h1;
            if (st_r.tick == SPI_HALF_LAST) begin
               st_nxt.ctl   = CTL_IDLE;
               st_nxt.ready = 1'b1;
            end
         end
         default: begin
            st_nxt.ctl = CTL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r       <= '0;
         st_r.ctl   <= CTL_IDLE;
         st_r.csN   <= 1'b1;
         st_r.ready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign feedbackClock  = st_r.skew[FB_SKEW_CYC-1];
   assign sysClock       = st_r.sysClk;
   assign burstFrame     = st_r.frame;
   assign burstDir       = st_r.dir;
   assign sampleBusOut   = st_r.busOut;
   assign sampleBusOe    = st_r.busOe;
   assign rxDataI        = st_r.rxI;
   assign rxDataQ        = st_r.rxQ;
   assign ctlReady       = st_r.ready;
   assign ctlReadByte    = st_r.rdByte;
   assign ctlReadValid   = st_r.rdValid;
   assign ctlSerialClock = st_r.sck;
   assign ctlSelectN     = st_r.csN;
   assign mosi           = CTL_FOUR_WIRE & st_r.mosiO;
   assign cpdioOut       = st_r.dioO;
   assign cpdioOe        = st_r.dioOe;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   ready_busy_a: assert property (ctlReady == (st_r.ctl == CTL_IDLE))
      else $error("ready does not match transaction state");
   read_valid_a: assert property (ctlReadValid |-> st_r.isRead ##1 !ctlReadValid)
      else $error("read valid not a single pulse of a read");
   select_frame_a: assert property (!ctlSelectN |-> st_r.ctl == CTL_SHIFT)
      else $error("select active outside a frame");
   four_wire_a: assert property (CTL_FOUR_WIRE |-> !cpdioOe)
      else $error("shared line driven in four-wire build");
   turn_release_a: assert property ((st_r.ctl == CTL_SHIFT && st_r.bitCnt >= HEADER_BITS &&
      st_r.bitCnt < dataStart) [*2] |-> !cpdioOe)
      else $error("shared line driven during turnaround");
   frame_pulse_a: assert property (burstFrame |=> !burstFrame)
      else $error("framing pulse longer than one cycle");
   dir_tx_a: assert property (sampleBusOe |-> burstDir && st_r.txAct)
      else $error("sample bus driven outside transmit burst");
   tx_start_a: assert property ($rose(sampleBusOe) |-> $past(st_r.halves) == TX_START_HALVES)
      else $error("transmit started at wrong latency");
   rx_late_a: assert property ($changed(rxDataQ) |-> $past(st_r.rxLat) == RX_LATENCY)
      else $error("receive data before latency elapsed");
   idle_lines_a: assert property (st_r.ctl == CTL_IDLE |-> ctlSelectN && !ctlSerialClock)
      else $error("serial lines not idle between frames");
endmodule
`default_nettype wire

/* File: testbench/radio_model.sv */
// Radio front-end model: master clock, sample bus and serial slave
`timescale 1ns/10ps
`default_nettype none
module radio_model
   import rf_iq_pkg::*;
(
   input  wire logic                clock,
   output logic                     masterClock,
   input  wire logic                burstFrame,
   input  wire logic                burstDir,
   output logic      [SAMPLE_W-1:0] radioBus,
   input  wire logic                ctlSerialClock,
   input  wire logic                ctlSelectN,
   input  wire logic                mosi,
   output logic                     miso,
   output logic      [31:0]         frameBits,
   output logic      [7:0]          frameCnt
);
   logic       rxOn;
   logic [7:0] idx;
   logic [7:0] rdByte;
   initial begin
      masterClock = 1'b0;
      rxOn = 1'b0;
      miso = 1'b0;
      frameBits = 32'h0;
      frameCnt = 8'h00;
   end
   // Offset keeps master edges off the bench clock edges
   initial begin
      #1;
      forever #62.5 masterClock = ~masterClock;
   end
   always @(posedge clock) if (burstFrame && !burstDir) rxOn <= ~rxOn;
   // I in high phase, Q in low phase; inverted pattern when released
   assign radioBus = rxOn ? (masterClock ? 12'h3A5 : 12'h5C3)
                          : ~(masterClock ? 12'h3A5 : 12'h5C3);
   always @(negedge ctlSelectN) begin
      frameCnt = 8'h00;
      frameBits = 32'h0;
   end
   always @(posedge ctlSerialClock) if (!ctlSelectN) begin
      frameBits = {frameBits[30:0], mosi};
      frameCnt = frameCnt + 8'h01;
   end
   // Read data set after each fall from the eighth clock of a read frame, MSB first
   always @(negedge ctlSerialClock) begin
      idx = frameCnt - 8'h08;
      rdByte = 8'hC3 + {5'h00, idx[5:3]};
      if (!ctlSelectN && frameCnt >= 8'h08 && frameBits[frameCnt - 8'h01]) begin
         miso = rdByte[3'h7 - idx[2:0]];
      end
   end
   always @(posedge ctlSelectN) miso = ~miso;
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the baseband I/Q port
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import rf_iq_pkg::*;
   logic clock, rst_n, masterClock, feedbackClock, sysClock, burstFrame, burstDir;
   logic [SAMPLE_W-1:0] sampleBusIn, sampleBusOut, radioBus, txDataI, txDataQ;
   logic [SAMPLE_W-1:0] rxDataI, rxDataQ;
   logic sampleBusOe, txEn, rxEn, ctlReady, ctlWriteStrobe, ctlReadStrobe, ctlReadValid;
   logic [BYTE_W-1:0] ctlWriteByte, ctlReadByte;
   logic [ADDR_W-1:0] ctlRegAddress;
   logic ctlSerialClock, ctlSelectN, mosi, miso, cpdioOut, cpdioOe;
   logic [31:0] frameBits;
   logic [7:0] frameCnt;
   int error_cnt, tests_run;
   assign sampleBusIn = sampleBusOe ? sampleBusOut : radioBus;
   rf_baseband_iq_port u_rf_baseband_iq_port (.clock(clock), .rst_n(rst_n),
      .masterClock(masterClock), .feedbackClock(feedbackClock), .sysClock(sysClock),
      .burstFrame(burstFrame), .burstDir(burstDir), .sampleBusIn(sampleBusIn),
      .sampleBusOut(sampleBusOut), .sampleBusOe(sampleBusOe), .txEn(txEn),
      .txDataI(txDataI), .txDataQ(txDataQ), .rxEn(rxEn), .rxDataI(rxDataI),
      .rxDataQ(rxDataQ), .ctlReady(ctlReady), .ctlWriteStrobe(ctlWriteStrobe),
      .ctlWriteByte(ctlWriteByte), .ctlReadStrobe(ctlReadStrobe),
      .ctlReadByte(ctlReadByte), .ctlReadValid(ctlReadValid),
      .ctlRegAddress(ctlRegAddress), .ctlSerialClock(ctlSerialClock),
      .ctlSelectN(ctlSelectN), .mosi(mosi), .miso(miso),
      .cpdioIn(cpdioOe ? cpdioOut : ~cpdioOut), .cpdioOut(cpdioOut), .cpdioOe(cpdioOe));
   radio_model u_radio_model (.clock(clock), .masterClock(masterClock),
      .burstFrame(burstFrame), .burstDir(burstDir), .radioBus(radioBus),
      .ctlSerialClock(ctlSerialClock), .ctlSelectN(ctlSelectN), .mosi(mosi),
      .miso(miso), .frameBits(frameBits), .frameCnt(frameCnt));
   always #5 clock = ~clock;
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic guard(input int n, input int lim);
      if (n >= lim) begin
         error_cnt++;
         $display("mismatch at %0t: wait ran out", $time);
         test_done();
      end
   endtask
   // Strobe cycles, then wait for ready collecting read bytes
   task automatic ctlXfer(input logic rd, input logic [ADDR_W-1:0] adr, input int nb,
                          input logic [7:0] b0, input logic [7:0] b1, input bit poke);
      int n, k;
      @(negedge clock);
      for (n = 0; n < 3000 && ctlReady !== 1'b1; n++) @(negedge clock);
      guard(n, 3000);
      ctlReadStrobe = rd;
      ctlWriteStrobe = !rd;
      ctlRegAddress = adr;
      ctlWriteByte = b0;
      @(negedge clock);
      check(ctlReady, 1'b0, "ready after strobe");
      if (nb == 2) begin
         ctlWriteByte = b1;
         @(negedge clock);
      end
      ctlReadStrobe = 1'b0;
      ctlWriteStrobe = 1'b0;
      k = 0;
      for (n = 0; n < 3000 && ctlReady !== 1'b1; n++) begin
         @(negedge clock);
         ctlWriteStrobe = poke && n == 40;
         if (ctlSelectN === 1'b0) check(ctlReady, 1'b0, "ready in frame");
         if (ctlReadValid === 1'b1) begin
            check(ctlReadByte, 8'(8'hC3 + k), "read byte");
            k++;
         end
      end
      guard(n, 3000);
      check(k, rd ? nb : 0, "read count");
      check(ctlSelectN, 1'b1, "select idle");
      check(ctlSerialClock, 1'b0, "clock idle");
      check(frameCnt, 8 + 8 * nb, "frame length");
      if (rd) check((frameBits >> (frameCnt - 8'h08)) & 32'hFF, {1'b1, adr}, "header");
      else if (nb == 2) check(frameBits, {8'h00, 1'b0, adr, b0, b1}, "wr frame");
      else check(frameBits, {16'h0000, 1'b0, adr, b0}, "wr frame");
   endtask
   task automatic frames(input logic dir);
      int n, f;
      f = 0;
      for (n = 0; n < 4; n++) begin
         @(negedge clock);
         f += (burstFrame === 1'b1);
      end
      check(f, 1, "frame pulses");
      check(burstDir, dir, "direction");
   endtask
   task automatic resetState();
      check(ctlReady, 1'b1, "reset ready");
      check(ctlSelectN, 1'b1, "reset select");
      check(sampleBusOe, 1'b0, "reset bus oe");
   endtask
   task automatic writeSingle();
      ctlXfer(1'b0, 7'h55, 1, 8'hA6, 8'h00, 1'b1);
   endtask
   task automatic writeBurst();
      ctlXfer(1'b0, 7'h2B, 2, 8'h81, 8'h7E, 1'b0);
   endtask
   task automatic readSingle();
      ctlXfer(1'b1, 7'h4C, 1, 8'h00, 8'h00, 1'b0);
   endtask
   task automatic readBurst();
      ctlXfer(1'b1, 7'h33, 2, 8'h00, 8'h00, 1'b0);
   endtask
   task automatic txBurst();
      int n;
      bit sI, sQ;
      int tS, tF;
      logic pS, pF;
      logic [SAMPLE_W-1:0] pB;
      sI = 0;
      sQ = 0;
      tS = 0;
      tF = 0;
      txDataI = 12'h1A5;
      txDataQ = 12'h2C6;
      txEn = 1'b1;
      frames(1'b1);
      repeat (8) @(negedge clock);
      check(sampleBusOe, 1'b0, "tx too early");
      for (n = 0; n < 100 && sampleBusOe !== 1'b1; n++) @(negedge clock);
      guard(n, 100);
      pS = sysClock;
      pF = feedbackClock;
      pB = sampleBusOut;
      for (n = 0; n < 40; n++) begin
         @(negedge clock);
         sI |= sampleBusOut === txDataI;
         sQ |= sampleBusOut === txDataQ;
         check(sampleBusOut === txDataI || sampleBusOut === txDataQ, 1, "tx");
         if (feedbackClock !== pF) check(sampleBusOut, pB, "data steady at fb edge");
         tS += (sysClock !== pS);
         tF += (feedbackClock !== pF);
         pS = sysClock;
         pF = feedbackClock;
         pB = sampleBusOut;
      end
      check(sI && sQ, 1'b1, "tx both phases");
      check(tS > 3, 1'b1, "system clock runs");
      check(tF > 3, 1'b1, "feedback clock runs");
      txEn = 1'b0;
      txDataI = 12'hFFF;
      frames(1'b1);
      repeat (30) @(negedge clock);
      check(sampleBusOe, 1'b0, "tx released");
      check(sampleBusOut === 12'hFFF, 1'b0, "tx input ignored");
   endtask
   task automatic rxBurst();
      int n;
      rxEn = 1'b1;
      frames(1'b0);
      repeat (40) @(negedge clock);
      check(rxDataI, 12'h000, "rx too early");
      for (n = 0; n < 300 && rxDataI !== 12'h3A5; n++) @(negedge clock);
      guard(n, 300);
      repeat (13) @(negedge clock);
      check(rxDataQ, 12'h5C3, "rx q");
      rxEn = 1'b0;
      frames(1'b0);
   endtask
   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      txEn = 1'b0;
      rxEn = 1'b0;
      txDataI = 12'h000;
      txDataQ = 12'h000;
      ctlWriteStrobe = 1'b0;
      ctlReadStrobe = 1'b0;
      ctlWriteByte = 8'h00;
      ctlRegAddress = 7'h00;
      error_cnt = 0;
      tests_run = 0;
      repeat (12) @(negedge clock);
      resetState();
      rst_n = 1'b1;
      repeat (4) @(negedge clock);
      writeSingle();
      writeBurst();
      readSingle();
      readBurst();
      txBurst();
      rxBurst();
      test_done();
   end
endmodule
`default_nettype wire
